// ---- shared/bus_matrix_pkg.sv ----
// Constants, field layouts and encodings shared by the bus matrix arbiter.
package bus_matrix_pkg;

    // ==========================================================
    // Matrix dimensions
    localparam int NUM_MASTERS = 16;
    localparam int NUM_SLAVES = 16;
    localparam int IDX_W = 4;

    // ==========================================================
    // Register word indices (byte address = index * 4)
    localparam logic [6:0] IDX_MASTER_CFG_BASE = 7'h00;
    localparam logic [6:0] IDX_SLAVE_CFG_BASE = 7'h10;
    localparam logic [6:0] IDX_PRIORITY_BASE = 7'h20;
    localparam logic [6:0] IDX_PRIORITY_END = 7'h3F;
    localparam logic [6:0] IDX_GRANT_STATUS_BASE = 7'h58;
    localparam logic [6:0] IDX_GRANT_STATUS_END = 7'h67;

    // ==========================================================
    // Master configuration layout and reset value
    localparam int MASTER_CONFIG_UNDEF_LSB = 0;
    localparam logic [2:0] MASTER_CONFIG_UNDEF_RESET = 3'h2;

    // ==========================================================
    // Slave configuration layout and reset values
    localparam int SLAVE_CONFIG_SLOT_LSB = 0;
    localparam int SLAVE_CONFIG_DEFK_LSB = 16;
    localparam int SLAVE_CONFIG_FIXM_LSB = 18;
    localparam int SLAVE_CONFIG_ARBK_LSB = 24;
    localparam logic [7:0] SLAVE_CONFIG_SLOT_RESET = 8'h10;
    localparam logic [1:0] SLAVE_CONFIG_DEFK_RESET = 2'h0;
    localparam logic [3:0] SLAVE_CONFIG_FIXM_RESET = 4'h0;
    localparam logic SLAVE_CONFIG_ARBK_RESET = 1'b0;

    // ==========================================================
    // Priority registers: one 4-bit field per master, eight per word
    localparam int PRI_W = 4;
    localparam int PRI_PER_WORD = 8;
    localparam logic [3:0] PRI_RESET = 4'h0;

    // ==========================================================
    // Encodings
    localparam logic [1:0] DEFK_NONE = 2'h0;
    localparam logic [1:0] DEFK_LAST = 2'h1;
    localparam logic [1:0] DEFK_FIXED = 2'h2;
    localparam logic ARBK_ROUND_ROBIN = 1'b0;
    localparam logic ARBK_FIXED_PRIO = 1'b1;
    localparam logic [2:0] UNDEF_INFINITE = 3'h0;
    localparam logic [2:0] UNDEF_ONE_BEAT = 3'h1;
    localparam logic [2:0] UNDEF_FOUR_BEAT = 3'h2;
    localparam logic [2:0] UNDEF_EIGHT_BEAT = 3'h3;
    localparam logic [2:0] UNDEF_SIXTEEN_BEAT = 3'h4;
    localparam logic [1:0] BURST_SINGLE = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_FIXED = 2'h2;

    typedef enum logic {LINK_OPEN, LINK_HELD} link_e;

endpackage

// ---- verilog/bus_matrix_arbiter.sv ----
// Per-slave arbitration and default-master granting for the high speed bus matrix.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
module bus_matrix_arbiter
    import bus_matrix_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Avalon-MM register slave, byte addressed
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Master request side
    input wire logic [NUM_MASTERS-1:0] m_req,
    input wire logic [NUM_MASTERS-1:0][IDX_W-1:0] m_slave,
    input wire logic [NUM_MASTERS-1:0][1:0] m_burst,
    input wire logic [NUM_MASTERS-1:0][4:0] m_len,
    // Slave side
    input wire logic [NUM_SLAVES-1:0] s_beat_done,
    output logic [NUM_SLAVES-1:0] s_grant_valid,
    output logic [NUM_SLAVES-1:0][IDX_W-1:0] s_grant_master
);

    // ==========================================================
    // Configuration storage
    logic [2:0] undef_kind_reg [NUM_MASTERS];
    logic [7:0] slot_reg [NUM_SLAVES];
    logic [1:0] defk_reg [NUM_SLAVES];
    logic [3:0] fixm_reg [NUM_SLAVES];
    logic arbk_reg [NUM_SLAVES];
    logic [PRI_W-1:0] pri_reg [NUM_SLAVES][NUM_MASTERS];

    logic [6:0] word_idx;
    logic [31:0] rd_value;
    logic wr_take;
    logic [31:0] wr_merged;
    logic [NUM_SLAVES-1:0] conn_flag;
    logic [NUM_SLAVES-1:0][IDX_W-1:0] owner_idx;

    assign word_idx = avs_address[8:2];
    assign wr_take = avs_write && !avs_waitrequest;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] slave_config_pack(input logic [7:0] slot, input logic [1:0] defk,
                                              input logic [3:0] fixm, input logic arbk);
        logic [31:0] res;
        res = 32'h0000_0000;
        res[SLAVE_CONFIG_SLOT_LSB +: 8] = slot;
        res[SLAVE_CONFIG_DEFK_LSB +: 2] = defk;
        res[SLAVE_CONFIG_FIXM_LSB +: 4] = fixm;
        res[SLAVE_CONFIG_ARBK_LSB] = arbk;
        return res;
    endfunction

    function automatic logic [31:0] pri_pack(input int s, input int half);
        logic [31:0] res;
        res = 32'h0000_0000;
        for (int m = 0; m < PRI_PER_WORD; m++) begin
            res[m*PRI_W +: PRI_W] = pri_reg[s][half*PRI_PER_WORD + m];
        end
        return res;
    endfunction

    // Lanes left out of a write keep their contents, and reserved bits read as zero, so they stay zero.
    // The merge is formed outside the clocked process, which then holds only non-blocking updates.
    assign wr_merged = be_merge(rd_value, avs_writedata, avs_byteenable);

    // ==========================================================
    // Register read mux
    always_comb begin
        int sel;
        sel = 0;
        rd_value = 32'h0000_0000;
        if (word_idx < IDX_SLAVE_CFG_BASE) begin
            sel = int'(word_idx[3:0]);
            rd_value[MASTER_CONFIG_UNDEF_LSB +: 3] = undef_kind_reg[sel];
        end else if (word_idx < IDX_PRIORITY_BASE) begin
            sel = int'(word_idx[3:0]);
            rd_value = slave_config_pack(slot_reg[sel], defk_reg[sel], fixm_reg[sel], arbk_reg[sel]);
        end else if (word_idx <= IDX_PRIORITY_END) begin
            sel = int'(word_idx[4:1]);
            rd_value = pri_pack(sel, int'(word_idx[0]));
        end else if (word_idx >= IDX_GRANT_STATUS_BASE && word_idx <= IDX_GRANT_STATUS_END) begin
            sel = int'(word_idx[3:0] - IDX_GRANT_STATUS_BASE[3:0]);
            rd_value[IDX_W] = conn_flag[sel];
            rd_value[IDX_W-1:0] = owner_idx[sel];
        end
    end

    // ==========================================================
    // Bus handshake: every access gets exactly one wait cycle.
    // The fixed wait state makes read data a registered copy, at the cost of two cycles per access.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rd_value : 32'h0000_0000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Register writes, merged per byte lane into the current contents.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                undef_kind_reg[m] <= MASTER_CONFIG_UNDEF_RESET;
            end
            for (int s = 0; s < NUM_SLAVES; s++) begin
                slot_reg[s] <= SLAVE_CONFIG_SLOT_RESET;
                defk_reg[s] <= SLAVE_CONFIG_DEFK_RESET;
                fixm_reg[s] <= SLAVE_CONFIG_FIXM_RESET;
                arbk_reg[s] <= SLAVE_CONFIG_ARBK_RESET;
                for (int m = 0; m < NUM_MASTERS; m++) begin
                    pri_reg[s][m] <= PRI_RESET;
                end
            end
        end else if (wr_take) begin
            if (word_idx < IDX_SLAVE_CFG_BASE) begin
                undef_kind_reg[word_idx[3:0]] <= wr_merged[MASTER_CONFIG_UNDEF_LSB +: 3];
            end else if (word_idx < IDX_PRIORITY_BASE) begin
                slot_reg[word_idx[3:0]] <= wr_merged[SLAVE_CONFIG_SLOT_LSB +: 8];
                defk_reg[word_idx[3:0]] <= wr_merged[SLAVE_CONFIG_DEFK_LSB +: 2];
                fixm_reg[word_idx[3:0]] <= wr_merged[SLAVE_CONFIG_FIXM_LSB +: 4];
                arbk_reg[word_idx[3:0]] <= wr_merged[SLAVE_CONFIG_ARBK_LSB];
            end else if (word_idx <= IDX_PRIORITY_END) begin
                for (int m = 0; m < PRI_PER_WORD; m++) begin
                    pri_reg[word_idx[4:1]][int'(word_idx[0])*PRI_PER_WORD + m] <=
                        wr_merged[m*PRI_W +: PRI_W];
                end
            end
        end
    end

    // ==========================================================
    // One independent arbiter per slave.
    // Pointer and link state are kept per slave, so traffic on one slave never steers another.
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slave
        logic [NUM_MASTERS-1:0] req_v;
        logic any_req;
        logic [IDX_W-1:0] win;
        logic [PRI_W-1:0] best_pri;
        logic own_req;
        logic [1:0] own_burst;
        logic [2:0] own_kind;
        logic [4:0] own_len;
        logic end_pred;
        logic rearb;
        link_e link_reg;
        logic [IDX_W-1:0] owner_reg;
        logic [IDX_W-1:0] rr_ptr_reg;
        logic [4:0] beat_cnt_reg;
        logic [7:0] slot_cnt_reg;

        always_comb begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                req_v[m] = m_req[m] && (m_slave[m] == IDX_W'(s));
            end
        end

        always_comb begin
            logic [IDX_W-1:0] cand;
            cand = '0;
            any_req = 1'b0;
            win = '0;
            best_pri = '0;
            if (arbk_reg[s] == ARBK_FIXED_PRIO) begin
                for (int m = 0; m < NUM_MASTERS; m++) begin
                    // Ascending scan with >= lets the higher index win a tie.
                    if (req_v[m] && (!any_req || pri_reg[s][m] >= best_pri)) begin
                        any_req = 1'b1;
                        win = IDX_W'(m);
                        best_pri = pri_reg[s][m];
                    end
                end
            end else begin
                for (int k = 1; k <= NUM_MASTERS; k++) begin
                    // Pointer resets to the top index so the first scan starts at master 0.
                    cand = rr_ptr_reg + IDX_W'(k);
                    if (!any_req && req_v[cand]) begin
                        any_req = 1'b1;
                        win = cand;
                    end
                end
            end
        end

        assign own_req = req_v[owner_reg];
        assign own_burst = m_burst[owner_reg];
        assign own_kind = undef_kind_reg[owner_reg];
        assign own_len = m_len[owner_reg];

        always_comb begin
            end_pred = 1'b0;
            case (own_burst)
                BURST_SINGLE: end_pred = 1'b1;
                BURST_FIXED: end_pred = (beat_cnt_reg + 5'h01) == own_len;
                BURST_INCR: begin
                    case (own_kind)
                        UNDEF_INFINITE: end_pred = 1'b0;
                        UNDEF_ONE_BEAT: end_pred = 1'b1;
                        UNDEF_FOUR_BEAT: end_pred = beat_cnt_reg[1:0] == 2'h3;
                        UNDEF_EIGHT_BEAT: end_pred = beat_cnt_reg[2:0] == 3'h7;
                        UNDEF_SIXTEEN_BEAT: end_pred = beat_cnt_reg[3:0] == 4'hF;
                        default: end_pred = 1'b0;
                    endcase
                end
                default: end_pred = 1'b1;
            endcase
        end

        // Re-arbitration only on idle cycles, or when the current beat completes a single
        // access, a predicted burst end, or a beat after the slot limit has run out.
        assign rearb = (link_reg == LINK_OPEN) || !own_req ||
                       (s_beat_done[s] && (end_pred || slot_cnt_reg == 8'h00));

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                link_reg <= LINK_OPEN;
                owner_reg <= '0;
                rr_ptr_reg <= '1;
            end else if (rearb) begin
                if (any_req) begin
                    // A new master costs one cycle; the connected one keeps going at once.
                    link_reg <= LINK_HELD;
                    owner_reg <= win;
                    rr_ptr_reg <= win;
                end else begin
                    case (defk_reg[s])
                        DEFK_NONE: link_reg <= LINK_OPEN;
                        DEFK_LAST: link_reg <= link_reg;
                        DEFK_FIXED: begin
                            link_reg <= LINK_HELD;
                            owner_reg <= fixm_reg[s];
                        end
                        default: link_reg <= LINK_OPEN;
                    endcase
                end
            end
        end

        // The slot counter also reloads on idle cycles, so a new burst always starts with a full slot.
        // It saturates at zero: a slot field of zero makes every beat a possible break point.
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                beat_cnt_reg <= 5'h00;
                slot_cnt_reg <= SLAVE_CONFIG_SLOT_RESET;
            end else if (rearb) begin
                beat_cnt_reg <= 5'h00;
                slot_cnt_reg <= slot_reg[s];
            end else begin
                if (s_beat_done[s]) begin
                    beat_cnt_reg <= beat_cnt_reg + 5'h01;
                end
                if (slot_cnt_reg != 8'h00) begin
                    slot_cnt_reg <= slot_cnt_reg - 8'h01;
                end
            end
        end

        // Grant outputs come straight from the link and owner flops, so slaves see no decode glitch.
        assign conn_flag[s] = (link_reg == LINK_HELD);
        assign owner_idx[s] = owner_reg;
        assign s_grant_valid[s] = conn_flag[s];
        assign s_grant_master[s] = owner_reg;
    end

endmodule

// ---- verification/bus_matrix_arbiter_sva.sv ----
// Checker with register bus and grant assertions for the bus matrix arbiter.
module matrix_arb_checker
    import bus_matrix_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Masters and slaves
    input wire logic [NUM_MASTERS-1:0] m_req,
    input wire logic [NUM_MASTERS-1:0][IDX_W-1:0] m_slave,
    input wire logic [NUM_SLAVES-1:0] s_beat_done,
    input wire logic [NUM_SLAVES-1:0] s_grant_valid,
    input wire logic [NUM_SLAVES-1:0][IDX_W-1:0] s_grant_master
);
    logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0] hit;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_comb begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                hit[s][m] = m_req[m] && (m_slave[m] == IDX_W'(s));
            end
        end
    end
    // ==========================================================
    // Register bus
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without a request");
    a_rdata_hold: assert property (!$past(avs_read) && !$past(avs_write) |-> $stable(avs_readdata))
        else $error("read data changed without an access");
    a_write_zero: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("read data not zero on a write");
    // ==========================================================
    // Grants, one arbiter per slave
    for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
        a_grant_hold: assert property (s_grant_valid[s] && hit[s][s_grant_master[s]] && !s_beat_done[s]
            |=> s_grant_valid[s] && $stable(s_grant_master[s])) else $error("grant moved in mid beat");
        a_idle_grant: assert property (|hit[s] && !(s_grant_valid[s] && hit[s][s_grant_master[s]])
            |=> s_grant_valid[s] && |($past(hit[s]) & (16'h1 << s_grant_master[s])))
            else $error("requested slave not given to a requester within one cycle");
        a_sole_keep: assert property (s_grant_valid[s] && hit[s] == (16'h1 << s_grant_master[s])
            |=> s_grant_valid[s] && $stable(s_grant_master[s])) else $error("sole requester lost its slave");
    end
endmodule
bind bus_matrix_arbiter matrix_arb_checker i_chk (.sys_clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .m_req, .m_slave, .s_beat_done, .s_grant_valid, .s_grant_master);

// ---- verification/matrix_bus_partners.sv ----
// Behavioural bus masters and slaves around the bus matrix arbiter.
module matrix_bus_partners
    import bus_matrix_pkg::*;
(
    // Clock, reset and traffic shape
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [4:0] span,
    // Grants seen by the slaves
    input wire logic [NUM_SLAVES-1:0] s_grant_valid,
    input wire logic [NUM_SLAVES-1:0][IDX_W-1:0] s_grant_master,
    // Requests and beat completions
    output logic [NUM_MASTERS-1:0] m_req,
    output logic [NUM_MASTERS-1:0][IDX_W-1:0] m_slave,
    output logic [NUM_MASTERS-1:0][1:0] m_burst,
    output logic [NUM_MASTERS-1:0][4:0] m_len,
    output logic [NUM_SLAVES-1:0] s_beat_done
);
    logic [NUM_SLAVES-1:0] rdy;
    int beats[NUM_MASTERS];
    // A slave completes beats only for the connected master that still addresses it.
    always_comb begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            s_beat_done[s] = s_grant_valid[s] && rdy[s] && m_req[s_grant_master[s]]
                && m_slave[s_grant_master[s]] == IDX_W'(s);
        end
    end
    // Idle masters keep changing their target fields, so stale values cannot pass for a request.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_req <= '0;
            m_slave <= '0;
            m_burst <= '0;
            m_len <= '0;
            rdy <= '0;
        end else begin
            rdy <= slow ? NUM_SLAVES'($urandom) : '1;
            for (int m = 0; m < NUM_MASTERS; m++) begin
                if (!m_req[m]) begin
                    m_req[m] <= $urandom % 4 == 0;
                    m_slave[m] <= IDX_W'($urandom % span);
                    m_burst[m] <= 2'($urandom);
                    m_len[m] <= 5'(1 + $urandom % 16);
                    beats[m] <= 0;
                end else if (s_beat_done[m_slave[m]] && s_grant_master[m_slave[m]] == IDX_W'(m)) begin
                    beats[m] <= beats[m] + 1;
                    m_req[m] <= beats[m] + 1 < (m_burst[m] inside {BURST_FIXED, BURST_INCR} ? m_len[m] : 1);
                end
            end
        end
    end
endmodule

// ---- verification/multilayer_bus_slave_arbiter_tb_top.sv ----
// Testbench top with a reference model and random traffic for the bus matrix arbiter.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; $display("ERROR %0t got %0h exp %0h", $time, got, exp); end end
module multilayer_bus_slave_arbiter_tb_top
    import bus_matrix_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals and model state
    logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, slow;
    logic [8:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d, q;
    logic [3:0] avs_byteenable;
    logic [4:0] span;
    logic [NUM_MASTERS-1:0] m_req;
    logic [NUM_MASTERS-1:0][IDX_W-1:0] m_slave;
    logic [NUM_MASTERS-1:0][1:0] m_burst;
    logic [NUM_MASTERS-1:0][4:0] m_len;
    logic [NUM_SLAVES-1:0] s_beat_done, s_grant_valid;
    logic [NUM_SLAVES-1:0][IDX_W-1:0] s_grant_master;
    int n_fail, n_checks, wi, sx;
    int undefined_burst_kind[16], slot[16], defk[16], fixm[16], arbk[16], mv[16], mo[16], cnt[16], sc[16], rr[16];
    int pri[16][16];
    bus_matrix_arbiter i_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .m_req, .m_slave, .m_burst, .m_len, .s_beat_done,
        .s_grant_valid, .s_grant_master);
    matrix_bus_partners i_far (.sys_clk, .rst_n, .slow, .span, .s_grant_valid, .s_grant_master, .m_req,
        .m_slave, .m_burst, .m_len, .s_beat_done);
    // The clock never stops, so the matrix is never frozen mid-access.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Reference model, one arbiter per slave
    task automatic step(input int s);
        int h[$];
        int o;
        int n;
        int w;
        bit re;
        o = mo[s];
        for (int m = 0; m < 16; m++) if (m_req[m] && m_slave[m] == 4'(s)) h.push_back(m);
        n = m_burst[o] == BURST_FIXED ? int'(m_len[o]) : m_burst[o] != BURST_INCR ? 1 : undefined_burst_kind[o] == 1 ? 1
            : undefined_burst_kind[o] inside {[2:4]} ? 1 << undefined_burst_kind[o] : 0;
        re = !mv[s] || !(o inside {h}) || (s_beat_done[s] && ((n > 0 && (cnt[s] + 1) % n == 0) || sc[s] == 0));
        if (!re) begin
            cnt[s] += s_beat_done[s];
            sc[s] = sc[s] > 0 ? sc[s] - 1 : 0;
            return;
        end
        cnt[s] = 0;
        sc[s] = slot[s];
        if (h.size() == 0) begin
            mv[s] = defk[s] == 1 ? mv[s] : int'(defk[s] == 2);
            mo[s] = defk[s] == 2 ? fixm[s] : mo[s];
            return;
        end
        w = h[0];
        foreach (h[k]) begin
            if (arbk[s] ? pri[s][h[k]] >= pri[s][w] : (h[k] + 15 - rr[s]) % 16 < (w + 15 - rr[s]) % 16) w = h[k];
        end
        mv[s] = 1;
        mo[s] = w;
        rr[s] = w;
    endtask
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            foreach (mv[i]) begin
                undefined_burst_kind[i] = 2;
                slot[i] = 16;
                defk[i] = 0;
                fixm[i] = 0;
                arbk[i] = 0;
                mv[i] = 0;
                mo[i] = 0;
                rr[i] = 15;
                foreach (pri[i][j]) pri[i][j] = 0;
            end
        end else begin
            wi = avs_address[8:2];
            if (avs_read && avs_waitrequest && wi == 89) sx = mv[1] * 16 + mo[1];
            for (int s = 0; s < 16; s++) step(s);
            if (avs_write && !avs_waitrequest && wi < 16 && avs_byteenable[0]) undefined_burst_kind[wi] = avs_writedata[2:0];
            if (avs_write && !avs_waitrequest && wi inside {[16:31]}) begin
                slot[wi - 16] = avs_writedata[7:0];
                defk[wi - 16] = avs_writedata[17:16];
                fixm[wi - 16] = avs_writedata[21:18];
                arbk[wi - 16] = avs_writedata[24];
            end
            if (avs_write && !avs_waitrequest && wi inside {[32:63]}) begin
                for (int m = 0; m < 8; m++) pri[(wi - 32) / 2][m + 8 * (wi % 2)] = avs_writedata[4 * m +: 4];
            end
        end
    end
    always @(negedge sys_clk) begin
        for (int s = 0; s < 16; s++) begin
            if (rst_n) `CHK(s_grant_valid[s], 1'(mv[s]))
            if (rst_n && mv[s]) `CHK(s_grant_master[s], 4'(mo[s]))
        end
    end
    // ==========================================================
    // Register bus tasks and sequence
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        avs_address = 9'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        slow = 1'b0;
        span = 5'h10;
        void'($urandom(32'hCEBD));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(9'h000, 32'h2);
        rd(9'h07C, 32'h10);
        rd(9'h0FC, 32'h0);
        rd(9'h110, 32'h0);
        for (int s = 0; s < 16; s++) begin
            d = {7'h0, 1'(s >> 2), 2'h0, 4'($urandom), 2'(s % 4), 8'h00, 8'($urandom % 8)};
            bus(1'b1, 9'(64 + 4 * s), d);
            bus(1'b1, 9'(128 + 8 * s), $urandom);
            bus(1'b1, 9'(132 + 8 * s), $urandom);
            bus(1'b1, 9'(4 * s), 32'(s % 8));
        end
        avs_byteenable <= 4'h2;
        bus(1'b1, 9'h000, 32'h0000_0707);
        avs_byteenable <= 4'hF;
        rd(9'h000, 32'h0);
        rd(9'h07C, d);
        for (int p = 0; p < 4; p++) begin
            span <= 5'(16 >> p);
            slow <= p[0];
            repeat (3000) @(posedge sys_clk);
        end
        bus(1'b0, 9'h164, 32'h0);
        `CHK(q, sx)
        summarize();
    end
    // The tests take about 12,200 cycles; a hang is cut off well beyond that.
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end
endmodule
